/* design/ifc_pkg.sv */
package ifc_pkg;

  // Reference and timebase rates
  localparam int REF_HZ = 10_000_000;
  localparam int TB_HZ = 2_000_000;
  localparam int REF_DIV = REF_HZ / TB_HZ;
  localparam int DIV_W = 3;

  // Gate intervals, in milliseconds and in timebase ticks
  localparam int GATE_LONG_MS = 200;
  localparam int GATE_MID_MS = 20;
  localparam int GATE_SHORT_MS = 2;
  localparam int GATE_LONG_TICKS = GATE_LONG_MS * (TB_HZ / 1000);
  localparam int GATE_MID_TICKS = GATE_MID_MS * (TB_HZ / 1000);
  localparam int GATE_SHORT_TICKS = GATE_SHORT_MS * (TB_HZ / 1000);
  localparam int GATE_W = 19;

  // Counter widths
  localparam int NIB_W = 4;
  localparam int PRE_W = 2 * NIB_W;
  localparam int CH0_W = 16;
  localparam int TOTAL_W = CH0_W + PRE_W;
  localparam int BUS_W = 8;

  // Values after reset
  localparam logic GATE_IDLE = 1'b1;
  localparam logic [PRE_W-1:0] PRE_RST = 8'h00;
  localparam logic [CH0_W-1:0] CH0_RST = 16'h0000;

  typedef enum logic [2:0] {
    RES_10HZ,
    RES_100HZ,
    RES_1KHZ,
    RES_10KHZ,
    RES_100KHZ,
    RES_1MHZ
  } ifc_res_e;

  typedef enum logic {
    ST_IDLE,
    ST_GATE
  } ifc_state_e;

  typedef struct packed {
    logic start;
    logic zero_span_mode;
    ifc_res_e resolution;
  } ifc_ctrl_s;

endpackage : ifc_pkg

/* design/ifc_sync_edge.sv */
module ifc_sync_edge
  import ifc_pkg::*;
#(
  parameter logic IDLE = 1'b0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic din,
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  always_comb begin
    next_meta = din;
    next_sync = meta;
    next_prev = sync;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Reset to the pin's idle level, so no false strobe or edge follows reset
      meta <= IDLE;
      sync <= IDLE;
      prev <= IDLE;
    end else if (ce) begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  // Edges are taken from the settled stage only
  assign level = sync;
  assign rise = sync & ~prev;
  assign fall = ~sync & prev;

endmodule : ifc_sync_edge

/* design/ifc_freq_counter.sv */
// Notes on behaviour
// - Divide 10 MHz reference by five
// - Zero-span mode selects host bus clock
// - Selected timebase clocks the gate timer
// - Count only while gate pulse low
// - Resolution selectable 10 Hz to 1 MHz
// - Gate 200 ms, 20 ms, else 2 ms
// - Two cascaded nibble counters form prescaler
// - Prescaler top bit clocks timer channel zero
// - Channel zero overflow raises overflow interrupt
// - Gate end raises done while acknowledge high
module ifc_freq_counter
  import ifc_pkg::*;
#(
  parameter int GATE_LONG = GATE_LONG_TICKS,
  parameter int GATE_MID = GATE_MID_TICKS,
  parameter int GATE_SHORT = GATE_SHORT_TICKS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire ifc_ctrl_s ctrl,
  input wire logic ref_clock,
  input wire logic host_bus_clock,
  input wire logic counted_if_input,
  input wire logic irq_acknowledge_line,
  input wire logic prescaler_read_n,
  input wire logic timer_select_n,
  input wire logic timer_read_n,
  output logic gate_window_pulse,
  output logic count_overflow_irq,
  output logic count_done_irq,
  output logic [BUS_W-1:0] internal_data_bus,
  output logic internal_data_bus_oe,
  output logic [TOTAL_W-1:0] total_count
);

  logic ref_rise;
  logic hclk_rise;
  logic if_rise;
  logic ack_lvl;
  logic pre_rd_lvl;
  logic tsel_lvl;
  logic trd_lvl;
  logic trd_rise;

  ifc_sync_edge u_ref (.clk(clk), .rst_b(rst_b), .ce(ce), .din(ref_clock),
    .level(), .rise(ref_rise), .fall());
  ifc_sync_edge u_hclk (.clk(clk), .rst_b(rst_b), .ce(ce), .din(host_bus_clock),
    .level(), .rise(hclk_rise), .fall());
  ifc_sync_edge u_if (.clk(clk), .rst_b(rst_b), .ce(ce), .din(counted_if_input),
    .level(), .rise(if_rise), .fall());
  ifc_sync_edge u_ack (.clk(clk), .rst_b(rst_b), .ce(ce), .din(irq_acknowledge_line),
    .level(ack_lvl), .rise(), .fall());
  ifc_sync_edge #(.IDLE(1'b1)) u_prd (.clk(clk), .rst_b(rst_b), .ce(ce),
    .din(prescaler_read_n), .level(pre_rd_lvl), .rise(), .fall());
  ifc_sync_edge #(.IDLE(1'b1)) u_tsel (.clk(clk), .rst_b(rst_b), .ce(ce),
    .din(timer_select_n), .level(tsel_lvl), .rise(), .fall());
  ifc_sync_edge #(.IDLE(1'b1)) u_trd (.clk(clk), .rst_b(rst_b), .ce(ce),
    .din(timer_read_n), .level(trd_lvl), .rise(trd_rise), .fall());

  // Timebase: reference divider and clock select
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic tb_tick;

  always_comb begin
    next_div_cnt = div_cnt;
    if (ref_rise) begin
      if (div_cnt == DIV_W'(REF_DIV - 1)) begin
        next_div_cnt = '0;
      end else begin
        next_div_cnt = div_cnt + 1'b1;
      end
    end
    tb_tick = ctrl.zero_span_mode ? hclk_rise
                                  : (ref_rise && div_cnt == DIV_W'(REF_DIV - 1));
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= '0;
    end else if (ce) begin
      div_cnt <= next_div_cnt;
    end
  end

  // Gate timer, channel two
  ifc_state_e state;
  ifc_state_e next_state;
  logic [GATE_W-1:0] gate_left;
  logic [GATE_W-1:0] next_gate_left;
  logic [GATE_W-1:0] gate_len;
  logic next_gate;
  logic gate_end;

  always_comb begin
    case (ctrl.resolution)
      RES_10HZ: gate_len = GATE_W'(GATE_LONG);
      RES_100HZ: gate_len = GATE_W'(GATE_MID);
      default: gate_len = GATE_W'(GATE_SHORT);
    endcase
  end

  always_comb begin
    next_state = state;
    next_gate_left = gate_left;
    next_gate = gate_window_pulse;
    gate_end = 1'b0;
    case (state)
      ST_IDLE: begin
        if (ctrl.start) begin
          next_state = ST_GATE;
          next_gate_left = gate_len;
          next_gate = 1'b0;
        end
      end
      ST_GATE: begin
        if (ctrl.start) begin
          next_gate_left = gate_len;
        end else if (tb_tick) begin
          if (gate_left <= GATE_W'(1)) begin
            next_state = ST_IDLE;
            next_gate = GATE_IDLE;
            gate_end = 1'b1;
          end else begin
            next_gate_left = gate_left - 1'b1;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_gate = GATE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      gate_left <= '0;
      gate_window_pulse <= GATE_IDLE;
    end else if (ce) begin
      state <= next_state;
      gate_left <= next_gate_left;
      gate_window_pulse <= next_gate;
    end
  end

  // Prescaler and channel zero
  logic [PRE_W-1:0] pre;
  logic [PRE_W-1:0] next_pre;
  logic [CH0_W-1:0] ch0;
  logic [CH0_W-1:0] next_ch0;
  logic next_ovf;
  logic next_done;
  logic [TOTAL_W-1:0] next_total;

  always_comb begin
    next_pre = pre;
    next_ch0 = ch0;
    next_ovf = count_overflow_irq;
    next_total = total_count;
    if (ctrl.start) begin
      next_pre = PRE_RST;
      next_ch0 = CH0_RST;
      next_ovf = 1'b0;
    end else if (if_rise && !gate_window_pulse) begin
      next_pre[NIB_W-1:0] = pre[NIB_W-1:0] + 1'b1;
      if (pre[NIB_W-1:0] == '1) begin
        next_pre[PRE_W-1:NIB_W] = pre[PRE_W-1:NIB_W] + 1'b1;
      end
      // Falling top bit advances channel zero
      if (pre == '1) begin
        next_ch0 = ch0 + 1'b1;
        if (ch0 == '1) begin
          next_ovf = 1'b1;
        end
      end
    end
    if (gate_end) begin
      next_total = {next_ch0, next_pre};
    end
  end

  // Acknowledge is sampled as a level, so a held low keeps the flag clear
  always_comb begin
    next_done = count_done_irq;
    if (!ack_lvl) begin
      next_done = 1'b0;
    end else if (gate_end) begin
      next_done = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre <= PRE_RST;
      ch0 <= CH0_RST;
      count_overflow_irq <= 1'b0;
      count_done_irq <= 1'b0;
      total_count <= '0;
    end else if (ce) begin
      pre <= next_pre;
      ch0 <= next_ch0;
      count_overflow_irq <= next_ovf;
      count_done_irq <= next_done;
      total_count <= next_total;
    end
  end

  // Host read port: timer gives low byte first, then high byte
  logic rd_hi;
  logic next_rd_hi;
  logic [BUS_W-1:0] next_bus;
  logic next_bus_oe;
  logic timer_rd;

  always_comb begin
    timer_rd = !tsel_lvl && !trd_lvl;
    next_rd_hi = rd_hi;
    if (ctrl.start) begin
      next_rd_hi = 1'b0;
    end else if (trd_rise && !tsel_lvl) begin
      next_rd_hi = ~rd_hi;
    end
    next_bus_oe = !pre_rd_lvl || timer_rd;
    if (!pre_rd_lvl) begin
      next_bus = pre;
    end else if (timer_rd) begin
      next_bus = rd_hi ? ch0[CH0_W-1:BUS_W] : ch0[BUS_W-1:0];
    end else begin
      next_bus = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_hi <= 1'b0;
      internal_data_bus <= '0;
      internal_data_bus_oe <= 1'b0;
    end else if (ce) begin
      rd_hi <= next_rd_hi;
      internal_data_bus <= next_bus;
      internal_data_bus_oe <= next_bus_oe;
    end
  end

endmodule : ifc_freq_counter

/* tb/ifc_sva.sv */
module ifc_sva
  import ifc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire ifc_ctrl_s ctrl,
  input wire logic irq_acknowledge_line,
  input wire logic prescaler_read_n,
  input wire logic timer_select_n,
  input wire logic timer_read_n,
  input wire logic gate_window_pulse,
  input wire logic count_overflow_irq,
  input wire logic count_done_irq,
  input wire logic [BUS_W-1:0] internal_data_bus,
  input wire logic internal_data_bus_oe,
  input wire logic [TOTAL_W-1:0] total_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_START: assert property (ce && ctrl.start |=> !gate_window_pulse)
    else $error("gate did not open");
  AST_GATE_MIN: assert property ($fell(gate_window_pulse) |-> !gate_window_pulse[*8])
    else $error("gate too short");
  AST_DONE: assert property ($rose(count_done_irq) |-> $rose(gate_window_pulse))
    else $error("done without gate end");
  AST_ACK_CLR: assert property (!irq_acknowledge_line[*4] |=> !count_done_irq)
    else $error("done not cleared");
  AST_TOTAL: assert property ($changed(total_count) |-> $rose(gate_window_pulse))
    else $error("total changed mid gate");
  AST_PRE_RD: assert property (!prescaler_read_n[*4] |=> internal_data_bus_oe)
    else $error("prescaler read not driven");
  AST_TMR_RD: assert property ((!timer_select_n && !timer_read_n)[*4] |=> internal_data_bus_oe)
    else $error("timer read not driven");
  AST_BUS_IDLE: assert property (!internal_data_bus_oe |-> internal_data_bus == '0)
    else $error("bus not idle");
  AST_OVF: assert property (count_overflow_irq && !ctrl.start |=> count_overflow_irq)
    else $error("overflow lost");
  cover property ($fell(gate_window_pulse));
  cover property ($rose(count_done_irq));
  cover property ($rose(internal_data_bus_oe));
endmodule : ifc_sva

bind ifc_freq_counter ifc_sva u_sva (.clk(clk), .rst_b(rst_b), .ce(ce), .ctrl(ctrl),
  .irq_acknowledge_line(irq_acknowledge_line), .prescaler_read_n(prescaler_read_n),
  .timer_select_n(timer_select_n), .timer_read_n(timer_read_n),
  .gate_window_pulse(gate_window_pulse), .count_overflow_irq(count_overflow_irq),
  .count_done_irq(count_done_irq), .internal_data_bus(internal_data_bus),
  .internal_data_bus_oe(internal_data_bus_oe), .total_count(total_count));

/* tb/ifc_host_model.sv */
module ifc_host_model
  import ifc_pkg::*;
(
  input wire logic clk,
  input wire logic [BUS_W-1:0] internal_data_bus,
  input wire logic internal_data_bus_oe,
  output logic prescaler_read_n,
  output logic timer_select_n,
  output logic timer_read_n,
  output logic irq_acknowledge_line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    prescaler_read_n = 1'b1;
    timer_select_n = 1'b1;
    timer_read_n = 1'b1;
    irq_acknowledge_line = 1'b0;
  end
  task automatic set_ack(input logic v);
    @(posedge clk);
    irq_acknowledge_line <= v;
  endtask : set_ack
  // Strobe goes up before select, else the byte toggle could be missed
  task automatic rd(input logic tmr, output logic [BUS_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk);
    if (tmr) begin
      timer_select_n <= 1'b0;
      timer_read_n <= 1'b0;
    end else begin
      prescaler_read_n <= 1'b0;
    end
    do begin
      @(posedge clk);
      n++;
    end while (internal_data_bus_oe !== 1'b1 && n < 20);
    // A read that never got the bus yields unknown data, which the compare counts
    if (internal_data_bus_oe === 1'b1) begin
      d = internal_data_bus;
    end else begin
      d = 'x;
    end
    prescaler_read_n <= 1'b1;
    timer_read_n <= 1'b1;
    repeat (5) @(posedge clk);
    timer_select_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask : rd
endmodule : ifc_host_model

/* tb/tb_top.sv */
module tb_top
  import ifc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  ifc_ctrl_s ctrl = '0;
  logic ref_clock = 1'b0;
  logic host_bus_clock = 1'b0;
  logic counted_if_input = 1'b0;
  logic ack, pre_n, sel_n, rd_n, gate, ovf, done, oe;
  logic [BUS_W-1:0] bus;
  logic [BUS_W-1:0] d;
  logic [TOTAL_W-1:0] total;
  int failures = 0;
  int n_compared = 0;
  int len;
  int tk;
  always #2 clk = ~clk;
  always #50 ref_clock = ~ref_clock;
  always #125 host_bus_clock = ~host_bus_clock;
  // Small gate counts keep the run short
  ifc_freq_counter #(.GATE_LONG(40), .GATE_MID(8), .GATE_SHORT(4)) dut (.clk(clk),
    .rst_b(rst_b), .ce(ce), .ctrl(ctrl), .ref_clock(ref_clock),
    .host_bus_clock(host_bus_clock), .counted_if_input(counted_if_input),
    .irq_acknowledge_line(ack), .prescaler_read_n(pre_n), .timer_select_n(sel_n),
    .timer_read_n(rd_n), .gate_window_pulse(gate), .count_overflow_irq(ovf),
    .count_done_irq(done), .internal_data_bus(bus), .internal_data_bus_oe(oe),
    .total_count(total));
  ifc_host_model host (.clk(clk), .internal_data_bus(bus), .internal_data_bus_oe(oe),
    .prescaler_read_n(pre_n), .timer_select_n(sel_n), .timer_read_n(rd_n),
    .irq_acknowledge_line(ack));
  task automatic check(input logic [TOTAL_W-1:0] got, input logic [TOTAL_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic conclude();
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  task automatic open(input logic [2:0] res, input logic zs);
    int n;
    n = 0;
    @(posedge clk);
    ctrl <= '{start: 1'b1, zero_span_mode: zs, resolution: ifc_res_e'(res)};
    @(posedge clk);
    ctrl.start <= 1'b0;
    while (gate !== 1'b0 && n < 9) begin
      @(posedge clk);
      n++;
    end
    check(24'(n < 9), 24'h000001);
  endtask : open
  task automatic wait_end();
    len = 0;
    while (gate === 1'b0 && len < 6000) begin
      @(posedge clk);
      len++;
    end
    check(24'(len < 6000), 24'h000001);
  endtask : wait_end
  initial begin
    #300000;
    failures++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    host.set_ack(1'b1);
    open(3'h0, 1'b0);
    repeat (20) @(posedge clk);
    // The last 20 pulses fall while frozen and must not count
    for (int k = 0; k < 320; k++) begin
      ce <= (k < 300);
      counted_if_input <= 1'b1;
      repeat (4) @(posedge clk);
      counted_if_input <= 1'b0;
      repeat (4) @(posedge clk);
    end
    check(24'(gate), 24'h000000);
    ce <= 1'b1;
    wait_end();
    check(total, 24'h00012c);
    check(24'(ovf), 24'h000000);
    check(24'(done), 24'h000001);
    host.rd(1'b0, d);
    check(24'(d), 24'h00002c);
    host.rd(1'b1, d);
    check(24'(d), 24'h000001);
    host.rd(1'b1, d);
    check(24'(d), 24'h000000);
    host.set_ack(1'b0);
    repeat (6) @(posedge clk);
    check(24'(done), 24'h000000);
    host.set_ack(1'b1);
    for (int r = 0; r < 8; r++) begin
      tk = r == 0 ? 40 : r == 1 ? 8 : 4;
      open(3'(r), 1'b0);
      wait_end();
      check(24'(len > (tk - 1) * 125 - 8 && len <= tk * 125 + 8), 24'h000001);
      check(total, 24'h000000);
    end
    check(24'(done), 24'h000001);
    open(3'h2, 1'b1);
    wait_end();
    check(24'(len > 3 * 62 - 8 && len <= 4 * 63 + 8), 24'h000001);
    conclude();
  end
endmodule : tb_top
